// >>> bench/udcm_src.sv
// Partner model: count pulse, direction, gate and latch sources
`default_nettype none
module udcm_src #(
  parameter int HOLD = 20  // Cycles each level stands, above the filter length
) (
  input  wire logic clock,     // Bench clock
  output logic      pulse_in,  // Count pulse pin
  output logic      dir_in,    // Direction pin, 1 up
  output logic      gate_in,   // Hardware gate pin
  output logic      latch_in   // Latch pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Idle levels and pin tasks
  // ----------------------------------------
  initial begin
    pulse_in = 1'h0;
    dir_in   = 1'h1;
    gate_in  = 1'h0;
    latch_in = 1'h0;
  end
  // Wait a number of clock edges
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Whole pulses; direction settles a full hold before each rising edge
  task automatic step(input int n, input logic up);
    repeat (n) begin
      dir_in <= up;
      idle(HOLD);
      pulse_in <= 1'h1;
      idle(HOLD);
      pulse_in <= 1'h0;
      idle(HOLD);
    end
  endtask
  // Pulse shorter than the filter, only when the bench asks for one
  task automatic glitch(input int len);
    pulse_in <= 1'h1;
    idle(len);
    pulse_in <= 1'h0;
    idle(HOLD);
  endtask
  // Gate level; a rising edge restarts after an automatic close
  task automatic gate(input logic v);
    gate_in <= v;
    idle(HOLD);
  endtask
  // One latch request
  task automatic latch();
    latch_in <= 1'h1;
    idle(HOLD);
    latch_in <= 1'h0;
    idle(HOLD);
  endtask
endmodule
`default_nettype wire

// >>> bench/updown_counter_modes_tb.sv
// Testbench: counter modes, flags, gate, filter and register checks
`default_nettype none
module updown_counter_modes_tb;
  import udcm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock;            // 25 MHz clock
  logic        rst_b;            // Reset, low
  logic [7:0]  addr;             // Register address
  logic [31:0] wdata;            // Write data
  logic        wr;               // Write strobe
  logic        rd;               // Read strobe
  logic [31:0] rdata;            // Read data
  logic        pulse_in;         // Count pin
  logic        dir_in;           // Direction pin
  logic        gate_in;          // Gate pin
  logic        latch_in;         // Latch pin
  logic        hw_irq;           // Interrupt
  logic        cmp_out;          // Comparator output
  int          err_count;        // Mismatches
  int          samples_checked;  // Comparisons
  int          irq_count;        // Interrupt pulses seen
  logic [31:0] v;                // Read value
  int          i0;               // Interrupt count before an event

  udcm_top #(.P_F1K(20), .P_F2K(10)) dut (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pulse_in(pulse_in), .dir_in(dir_in), .gate_in(gate_in),
    .latch_in(latch_in), .hw_irq(hw_irq), .cmp_out(cmp_out));
  udcm_src #(.HOLD(20)) src (
    .clock(clock), .pulse_in(pulse_in), .dir_in(dir_in), .gate_in(gate_in),
    .latch_in(latch_in));

  // Clock generator
  always #20 clock = ~clock;
  // Count interrupt pulses
  always @(posedge clock) begin
    if (hw_irq === 1'h1) irq_count <= irq_count + 1;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clock);
    wr    <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clock);
    rd   <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic cnt(input logic [31:0] exp);
    rreg(OFS_COUNT, v);
    chk("count", v, exp);
  endtask
  // Software gate 0 then 1, then a checked read of the load value
  task automatic swrestart(input logic [31:0] c, input logic [31:0] ld);
    wreg(OFS_CTRL, c & 32'hFFFF_FFF7);
    wreg(OFS_CTRL, c | 32'h0000_0008);
    rreg(OFS_LOAD, v);
    chk("load", v, ld);
  endtask
  task automatic results();
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rreg(OFS_CTRL, v);
    chk("ctrl", v, CTRL_RST);
    wreg(OFS_COUNT, 32'h1234_5678);
    cnt(32'h0000_0000);
    rreg(8'h20, v);
    chk("unmapped", v, 32'h0000_0000);
  endtask
  // Continuous: wrap both ways, sticky flags, overflow irq only
  task automatic t_cont();
    wreg(OFS_LOAD, 32'h7FFF_FFFE);
    swrestart(32'h0001_1084, 32'h7FFF_FFFE);
    cnt(32'h7FFF_FFFE);
    i0 = irq_count;
    src.step(2, 1'h1);
    cnt(CNT_MIN);
    chk("ovf irq", irq_count, i0 + 1);
    src.step(1, 1'h0);
    cnt(CNT_MAX);
    chk("unf irq off", irq_count, i0 + 1);
    rreg(OFS_STATUS, v);
    chk("flags", v[1:0], 2'h3);
    wreg(OFS_STATUS, 32'h0000_0003);
    rreg(OFS_STATUS, v);
    chk("flags clr", v[1:0], 2'h0);
    src.glitch(4);
    cnt(CNT_MAX);
  endtask
  // Single shot without direction: close on wrap, resume or reload
  task automatic t_once();
    wreg(OFS_CTRL, 32'h0001_1009);
    src.step(1, 1'h1);
    cnt(CNT_MIN);
    rreg(OFS_STATUS, v);
    chk("auto closed", v[4:3], 2'h2);
    src.step(1, 1'h1);
    cnt(CNT_MIN);
    swrestart(32'h0001_1001, 32'h7FFF_FFFE);
    cnt(CNT_MIN);
    src.step(1, 1'h0);
    cnt(CNT_MAX);
    swrestart(32'h0001_1005, 32'h7FFF_FFFE);
    cnt(32'h7FFF_FFFE);
  endtask
  // Forward: comparator irq, latch, end reload, gate close irq, restart
  task automatic t_fwd();
    wreg(OFS_LOAD, 32'h0000_0005);
    wreg(OFS_END, 32'h0000_0008);
    wreg(OFS_CMP, 32'h0000_0006);
    wreg(OFS_CTRL, 32'h0001_167A);
    src.gate(1'h1);
    cnt(32'h0000_0005);
    i0 = irq_count;
    src.step(1, 1'h1);
    chk("cmp out", cmp_out, 1'h1);
    chk("cmp irq", irq_count, i0 + 1);
    src.step(1, 1'h1);
    src.latch();
    rreg(OFS_LATCH, v);
    chk("latch", v, 32'h0000_0007);
    src.step(1, 1'h1);
    cnt(32'h0000_0005);
    src.step(1, 1'h1);
    cnt(32'h0000_0005);
    i0 = irq_count;
    src.gate(1'h0);
    chk("gate irq", irq_count, i0 + 1);
    src.gate(1'h1);
    src.step(1, 1'h0);
    cnt(32'h0000_0004);
  endtask
  // Backward: end reload, then counting past the upper limit
  task automatic t_bwd();
    wreg(OFS_LOAD, 32'hFFFF_FFFE);
    wreg(OFS_END, 32'hFFFF_FFFB);
    wreg(OFS_CTRL, 32'h0001_101B);
    src.gate(1'h0);
    src.gate(1'h1);
    src.step(2, 1'h0);
    cnt(32'hFFFF_FFFC);
    src.step(1, 1'h0);
    cnt(32'hFFFF_FFFE);
    wreg(OFS_STATUS, 32'h0000_0003);
    wreg(OFS_LOAD, CNT_MAX);
    src.gate(1'h0);
    src.gate(1'h1);
    src.step(1, 1'h1);
    cnt(CNT_MIN);
    rreg(OFS_STATUS, v);
    chk("no flag", v[0], 1'h0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'h0;
    rst_b = 1'h0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'h0;
    rd = 1'h0;
    err_count = 0;
    samples_checked = 0;
    irq_count = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset();
    t_cont();
    t_once();
    t_fwd();
    t_bwd();
    results();
  end
  initial begin
    #(40 * 30000);
    err_count++;
    results();
  end
endmodule
`default_nettype wire

// >>> hw/udcm_pkg.sv
// Package: constants of the up/down counter channel
`default_nettype none
package udcm_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LOAD   = 8'h04;
  localparam logic [7:0] OFS_END    = 8'h08;
  localparam logic [7:0] OFS_CMP    = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LATCH  = 8'h18;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CB_MODE  = 0;  // [1:0] count mode
  localparam int CB_ABORT = 2;  // Gate function: 1 abort
  localparam int CB_SWG   = 3;  // Software gate
  localparam int CB_HWEN  = 4;  // Hardware gate evaluation
  localparam int CB_IEGC  = 5;  // Gate closing irq enable
  localparam int CB_IECMP = 6;  // Comparator irq enable
  localparam int CB_IEOV  = 7;  // Overflow irq enable
  localparam int CB_IEUN  = 8;  // Underflow irq enable
  localparam int CB_CHAR  = 9;  // [10:9] comparator mode
  localparam int CB_FSEL  = 12; // [14:12] count freq select
  localparam int CB_LSEL  = 16; // [18:16] latch freq select
  // Control reset: 60 kHz inputs, 10 kHz latch
  localparam logic [31:0] CTRL_RST = 32'h0003_5000;
  // Status bits
  localparam int SB_OVF = 0;
  localparam int SB_UNF = 1;
  localparam int SB_CMP = 2;
  localparam int SB_GATE = 3;
  localparam int SB_AUTO = 4;
  // ----------------------------------------
  // Modes and count limits
  // ----------------------------------------
  typedef enum logic [1:0] {
    M_CONT = 2'h0, M_ONCE = 2'h1, M_FWD = 2'h2, M_BWD = 2'h3
  } udcm_mode_t;
  localparam logic signed [31:0] CNT_MIN = 32'sh8000_0000;
  localparam logic signed [31:0] CNT_MAX = 32'sh7FFF_FFFF;
  // ----------------------------------------
  // Shortest pulse per frequency, in ns
  // ----------------------------------------
  localparam int CLK_NS  = 40;
  localparam int T1K_NS  = 400000;
  localparam int T2K_NS  = 200000;
  localparam int T5K_NS  = 80000;
  localparam int T10K_NS = 40000;
  localparam int T30K_NS = 13000;
  localparam int T60K_NS = 6700;
  localparam int F1K_CYC  = (T1K_NS + CLK_NS - 1) / CLK_NS;
  localparam int F2K_CYC  = (T2K_NS + CLK_NS - 1) / CLK_NS;
  localparam int F5K_CYC  = (T5K_NS + CLK_NS - 1) / CLK_NS;
  localparam int F10K_CYC = (T10K_NS + CLK_NS - 1) / CLK_NS;
  localparam int F30K_CYC = (T30K_NS + CLK_NS - 1) / CLK_NS;
  localparam int F60K_CYC = (T60K_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// >>> hw/udcm_top.sv
// Module: up/down counter channel with gate, filters and registers
//
// Behaviour
// - Gate falling edge irq, software gate open
// - Comparator trigger raises enabled irq
// - Overflow raises enabled irq
// - Underflow raises enabled irq
// - Selectable filter for pulse, direction, gate
// - Separate filter selection for latch input
// - Continuous mode counts from load value
// - Up at upper limit wraps low
// - Down at lower limit wraps high
// - Sticky overflow/underflow flags, cleared by command
// - Full signed 32-bit limits
// - Single-shot counts once either direction
// - Single-shot wrap loads opposite limit, closes
// - Interrupt gate function resumes current value; forward and backward modes reload instead
// - Cancel gate function reloads load value
// - Forward: after end-1, reload and close
// - Forward end range, may pass low limit
// - Backward: after end+1, reload and close
// - Directed single-shot restarts from load
// - Backward end range, may pass high limit
// - Abort gate function restarts from load
//
// Chosen here: the register addresses and the plain strobed port.
`default_nettype none
module udcm_top
  import udcm_pkg::*;
#(
  parameter int P_F1K = F1K_CYC, // Filter cycles at 1 kHz
  parameter int P_F2K = F2K_CYC  // Filter cycles at 2 kHz
) (
  input  wire logic        clock,    // 25 MHz clock
  input  wire logic        rst_b,    // Async reset, low
  input  wire logic [7:0]  addr,     // Register byte address
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic        wr,       // Write strobe
  input  wire logic        rd,       // Read strobe
  output logic      [31:0] rdata,    // Read data, next cycle
  input  wire logic        pulse_in, // Count pulse pin
  input  wire logic        dir_in,   // Direction pin, 1 up
  input  wire logic        gate_in,  // Hardware gate pin
  input  wire logic        latch_in, // Latch pin
  output logic             hw_irq,   // Interrupt pulse
  output logic             cmp_out   // Comparator output
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1; // First reset stage
  logic srst_b; // Released reset

  // Two-stage reset release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      srst_b <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      srst_b <= rst_s1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic        [31:0] ctrl;      // Control word
  logic signed [31:0] load;      // Load value
  logic signed [31:0] end_v;     // End value
  logic signed [31:0] cmp_v;     // Comparison value
  logic signed [31:0] cnt;       // Counter
  logic signed [31:0] latch_v;   // Latched count
  logic               ovf_flag;  // Sticky overflow
  logic               underflow_flag; // Sticky underflow
  logic               auto_cl;   // Gate closed by hardware
  logic               gate_eff;  // Internal gate
  logic               cmp_q;     // Comparator state
  logic               status_clear_cmd; // Status write
  udcm_mode_t         mode;      // Count mode

  assign mode = udcm_mode_t'(ctrl[CB_MODE+:2]);
  assign status_clear_cmd = wr && (addr == OFS_STATUS);

  // Software writes
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      ctrl  <= CTRL_RST;
      load  <= '0;
      end_v <= '0;
      cmp_v <= '0;
    end else if (wr) begin
      case (addr)
        OFS_CTRL: ctrl  <= wdata;
        OFS_LOAD: load  <= wdata;
        OFS_END:  end_v <= wdata;
        OFS_CMP:  cmp_v <= wdata;
        default:  ;
      endcase
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        OFS_CTRL:   rdata <= ctrl;
        OFS_LOAD:   rdata <= load;
        OFS_END:    rdata <= end_v;
        OFS_CMP:    rdata <= cmp_v;
        OFS_COUNT:  rdata <= cnt;
        OFS_STATUS: rdata <= {27'h000_0000, auto_cl, gate_eff,
                              cmp_q, underflow_flag, ovf_flag};
        OFS_LATCH:  rdata <= latch_v;
        default:    rdata <= '0; // Unmapped reads zero
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------
  // Input synchronisers and pulse filters
  // ----------------------------------------
  logic [3:0] pins;   // Raw pins
  logic [3:0] filt;   // Filtered levels
  logic [3:0] filt_q; // Filtered, delayed

  assign pins = {latch_in, gate_in, dir_in, pulse_in};

  // Shortest accepted pulse for a select code
  function automatic logic [13:0] lim(input logic [2:0] s);
    case (s)
      3'h0:    lim = 14'(P_F1K);
      3'h1:    lim = 14'(P_F2K);
      3'h2:    lim = 14'(F5K_CYC);
      3'h3:    lim = 14'(F10K_CYC);
      3'h4:    lim = 14'(F30K_CYC);
      default: lim = 14'(F60K_CYC);
    endcase
  endfunction

  for (genvar i = 0; i < 4; i++) begin : g_in
    logic [2:0]  sy;  // Sync stages
    logic [13:0] run; // Stable-run length
    logic [13:0] need; // Cycles required
    // Latch has its own select, others share one
    assign need = (i == 3) ? lim(ctrl[CB_LSEL+:3])
                           : lim(ctrl[CB_FSEL+:3]);
    // Three-stage synchroniser
    always_ff @(posedge clock or negedge srst_b) begin
      if (!srst_b) begin
        sy <= '0;
      end else begin
        sy <= {sy[1:0], pins[i]};
      end
    end
    // Accept a new level only after it stood long enough
    always_ff @(posedge clock or negedge srst_b) begin
      if (!srst_b) begin
        run       <= '0;
        filt[i]   <= 1'b0;
        filt_q[i] <= 1'b0;
      end else begin
        filt_q[i] <= filt[i];
        if (sy[2] == filt[i] || sy[1] != sy[2]) begin
          run <= '0;
        end else if (run >= need - 14'h0001) begin
          run     <= '0;
          filt[i] <= sy[2];
        end else begin
          run <= run + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Gate logic
  // ----------------------------------------
  logic up;        // Direction, 1 counts up
  logic step;      // Accepted count pulse
  logic hw_rise;   // Gate pin rising
  logic hw_fall;   // Gate pin falling
  logic sw_q;      // Software gate delayed
  logic gate_open; // Software and hardware gate
  logic gate_q;    // Internal gate delayed
  logic restart;   // Internal gate opened
  logic reload;    // Restart takes load value
  logic close_e;   // Hardware closes gate
  logic latch_e;   // Latch rising

  assign up        = filt[1];
  assign hw_rise   = filt[2] & ~filt_q[2];
  assign hw_fall   = ~filt[2] & filt_q[2];
  assign latch_e   = filt[3] & ~filt_q[3];
  assign gate_open = ctrl[CB_SWG] & (~ctrl[CB_HWEN] | filt[2]);
  assign gate_eff  = gate_open & ~auto_cl;
  assign restart   = gate_eff & ~gate_q;
  assign step      = filt[0] & ~filt_q[0] & gate_eff;
  // Directed single-shot always reloads, else abort does
  assign reload = (mode == M_FWD) || (mode == M_BWD)
                  || ctrl[CB_ABORT];

  // Gate edge history
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      gate_q <= 1'b0;
      sw_q   <= 1'b0;
    end else begin
      gate_q <= gate_eff;
      sw_q   <= ctrl[CB_SWG];
    end
  end

  // Automatic closure; reopened by a fresh gate edge
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      auto_cl <= 1'b0;
    end else if (close_e) begin
      auto_cl <= 1'b1;
    end else if (ctrl[CB_HWEN] ? hw_rise : (ctrl[CB_SWG] & ~sw_q)) begin
      auto_cl <= 1'b0;
    end
  end

  // ----------------------------------------
  // Counter next value
  // ----------------------------------------
  logic signed [31:0] next_cnt; // Next counter value
  logic               ovf_e;    // Overflow event
  logic               unf_e;    // Underflow event

  always_comb begin
    next_cnt = cnt;
    ovf_e    = 1'b0;
    unf_e    = 1'b0;
    close_e  = 1'b0;
    if (restart) begin
      // Abort or a directed mode reloads, interrupt keeps value otherwise
      next_cnt = reload ? load : cnt;
    end else if (step) begin
      case (mode)
        M_FWD: begin
          if (up && cnt == end_v - 32'sd1) begin
            next_cnt = load;
            close_e  = 1'b1;
          end else if (up) begin
            next_cnt = cnt + 32'sd1;
          end else begin
            next_cnt = cnt - 32'sd1;
          end
        end
        M_BWD: begin
          if (!up && cnt == end_v + 32'sd1) begin
            next_cnt = load;
            close_e  = 1'b1;
          end else if (up) begin
            next_cnt = cnt + 32'sd1;
          end else begin
            next_cnt = cnt - 32'sd1;
          end
        end
        default: begin
          // Continuous and undirected single-shot
          if (up && cnt == CNT_MAX) begin
            next_cnt = CNT_MIN;
            ovf_e    = 1'b1;
            close_e  = (mode == M_ONCE);
          end else if (!up && cnt == CNT_MIN) begin
            next_cnt = CNT_MAX;
            unf_e    = 1'b1;
            close_e  = (mode == M_ONCE);
          end else if (up) begin
            next_cnt = cnt + 32'sd1;
          end else begin
            next_cnt = cnt - 32'sd1;
          end
        end
      endcase
    end
  end

  // Counter and latch registers
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      cnt     <= '0;
      latch_v <= '0;
    end else begin
      cnt <= next_cnt;
      if (latch_e && gate_eff) begin
        latch_v <= cnt;
      end
    end
  end

  // Sticky flags, a new event beats the clear
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      ovf_flag       <= 1'b0;
      underflow_flag <= 1'b0;
    end else begin
      ovf_flag <= ovf_e | (ovf_flag &
                  ~(status_clear_cmd & wdata[SB_OVF]));
      underflow_flag <= unf_e | (underflow_flag &
                        ~(status_clear_cmd & wdata[SB_UNF]));
    end
  end

  // ----------------------------------------
  // Comparator and interrupt
  // ----------------------------------------
  logic cmp_c; // Comparison holds
  logic cmp_e; // Comparator triggered
  logic gc_e;  // Gate closing event

  always_comb begin
    case (ctrl[CB_CHAR+:2])
      2'h1:    cmp_c = (cnt >= cmp_v);
      2'h2:    cmp_c = (cnt <= cmp_v);
      2'h3:    cmp_c = (cnt == cmp_v);
      default: cmp_c = 1'b0; // No comparison
    endcase
  end
  assign cmp_e = cmp_c & ~cmp_q;
  assign gc_e  = hw_fall & ctrl[CB_SWG];

  // Comparator state and output
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      cmp_q   <= 1'b0;
      cmp_out <= 1'b0;
    end else begin
      cmp_q   <= cmp_c;
      cmp_out <= cmp_c;
    end
  end

  // One-cycle interrupt from enabled events
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      hw_irq <= 1'b0;
    end else begin
      hw_irq <= (ctrl[CB_IEGC] & gc_e)
              | (ctrl[CB_IECMP] & cmp_e)
              | (ctrl[CB_IEOV] & ovf_e)
              | (ctrl[CB_IEUN] & unf_e);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!srst_b);

  a_wrap_up: assert property (step && up && mode == M_CONT
    && cnt == CNT_MAX |=> cnt == CNT_MIN && ovf_flag)
    else $error("up wrap wrong");
  a_wrap_down: assert property (step && !up && mode == M_CONT
    && cnt == CNT_MIN |=> cnt == CNT_MAX && underflow_flag)
    else $error("down wrap wrong");
  a_once_close: assert property (step && mode == M_ONCE
    && up && cnt == CNT_MAX |=> auto_cl ##1 !gate_eff)
    else $error("single-shot did not close");
  a_fwd_end: assert property (step && up && mode == M_FWD
    && cnt == end_v - 32'sd1 |=> cnt == $past(load) && auto_cl)
    else $error("forward end wrong");
  a_bwd_end: assert property (step && !up && mode == M_BWD
    && cnt == end_v + 32'sd1 |=> cnt == $past(load) && auto_cl)
    else $error("backward end wrong");
  a_gate_hold: assert property (!gate_eff |=> $stable(cnt))
    else $error("count while gate closed");
  a_load_restart: assert property (restart && reload
    |=> cnt == $past(load))
    else $error("restart without reload");
  a_keep_restart: assert property (restart && !reload
    |=> $stable(cnt))
    else $error("interrupt restart changed value");
  a_ovf_irq: assert property (ovf_e && ctrl[CB_IEOV]
    |=> hw_irq ##1 !hw_irq || ovf_e || unf_e || cmp_e || gc_e)
    else $error("overflow irq missing");
  a_unf_irq: assert property (unf_e && ctrl[CB_IEUN] |=> hw_irq)
    else $error("underflow irq missing");
  a_gclose_irq: assert property (gc_e && ctrl[CB_IEGC] |=> hw_irq)
    else $error("gate closing irq missing");
  a_flag_sticky: assert property (ovf_flag && !status_clear_cmd
    |=> ovf_flag)
    else $error("overflow flag lost");

  c_wrap: cover property (ovf_e ##[1:50] unf_e);
  c_restart: cover property (close_e ##[1:1000] restart);
  c_cmp_irq: cover property (cmp_e && ctrl[CB_IECMP]);
endmodule
`default_nettype wire
